// ===== bench/address_decode_shadow_map_tb.sv
/*
  Self-checking bench for the address decode and shadow map block.
  Assumes the host model drives all bus inputs at falling edges.
*/
`timescale 1ns/1ns
`default_nettype none
module address_decode_shadow_map_tb;
  // ==========================================================
  // Clock, configuration inputs and wiring
  logic             core_clk_i = 1'b0;
  logic             sys_rst_i = 1'b1;
  logic             lock = 1'b0;
  logic             bios = 1'b0;
  logic             adp = 1'b0;
  logic             vid = 1'b0;
  logic             rsz = 1'b0;
  logic             bsz = 1'b0;
  logic      [15:0] q;
  int               n;
  logic             h;
  logic             wb;
  int               miscompares = 0;
  int               samples_checked = 0;
  int               cycles = 0;
  wire logic [15:0] io_addr, io_wdata, rdata;
  wire logic [23:0] mem_addr;
  wire logic [3:0]  t_states;
  wire logic        io_wr, io_rd, hit_io, ready, mem_io, mem_wr, start, blk;
  wire logic        rom_lo_n, rom_hi_n, fm, hit, s0_n, s1_n, spd, pen, mio, pclk;
  always #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  addr_decode_shadow u_dut (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .io_addr_i(io_addr),
    .io_wdata_i(io_wdata), .io_wr_i(io_wr), .io_rd_i(io_rd), .io_rdata_o(rdata),
    .io_hit_o(hit_io), .processor_ready_out_o(ready), .mem_addr_i(mem_addr),
    .mem_io_i(mem_io), .mem_wr_i(mem_wr), .cycle_start_i(start), .lock_i(lock),
    .bios_shadow_bit_i(bios), .adapter_shadow_bit_i(adp), .video_shadow_bit_i(vid),
    .rom_size_bit_i(rsz), .base_memory_size_bit_i(bsz), .rom_select_low_n_o(rom_lo_n),
    .rom_select_high_n_o(rom_hi_n), .first_megabyte_select_o(fm),
    .onboard_memory_hit_o(hit), .offboard_status_0_n_o(s0_n),
    .offboard_status_1_n_o(s1_n), .offboard_memory_or_io_o(mio), .write_blocked_o(blk),
    .speed_select_o(spd), .t_states_o(t_states), .pclk_o(pclk), .pclk_en_o(pen));
  host_bus_model u_host (
    .clk_i(core_clk_i), .ready_i(ready), .rdata_i(rdata), .hit_i(hit_io),
    .blk_i(blk), .addr_o(io_addr), .wdata_o(io_wdata), .wr_o(io_wr), .rd_o(io_rd),
    .maddr_o(mem_addr), .mio_o(mem_io), .mwr_o(mem_wr), .start_o(start));
  // ==========================================================
  // Shared checks and bus helpers
  task automatic chk(input string s, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input int e);
    u_host.io_acc(1'b1, a, d, q, n, h);
    chk("wr_ready", 24'(n), 24'(e));
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    u_host.io_acc(1'b0, a, 16'h0000, q, n, h);
    chk("rd_ready", 24'(n), 24'h000001);
    chk("rd_data", 24'(q), 24'(e));
  endtask
  task automatic mc(input string s, input logic [23:0] a, input logic m, input logic w,
                    input logic e);
    logic e0;
    logic e1;
    u_host.mem_cyc(a, m, w, wb);
    e0 = !(m && !e && w);
    e1 = !(m && !e && !w);
    if (m)
      chk(s, 24'({fm, hit, s0_n, s1_n, mio}), 24'({a < 24'h100000, e, e0, e1, m}));
    else
      chk(s, 24'({fm, hit, mio}), 24'({1'b0, e, 1'b0}));
  endtask
  task automatic pulses(input int e);
    int c;
    int p;
    c = 0;
    p = 0;
    repeat (20) begin
      @(negedge core_clk_i);
      if (pen === 1'b1)
        c++;
      if (pclk === 1'b1)
        p++;
    end
    chk("pclk_en", 24'(c), 24'(e));
    chk("pclk_level", 24'(p), 24'(e));
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(16'h0028, 16'h801f);
    rd(16'h002a, 16'h0000);
    rd(16'h002c, 16'h0000);
    rd(16'h002e, 16'h0000);
    chk("t_states", 24'({spd, t_states}), 24'h000006);
    u_host.io_acc(1'b0, 16'h0030, 16'h0000, q, n, h);
    chk("unmapped", 24'({h, n == -1}), 24'h000001);
    wr(16'h002a, 16'h9f1f, 1);
    rd(16'h002a, 16'h9f1f);
    wr(16'h002e, 16'ha55a, 1);
    rd(16'h002e, 16'ha55a);
    wr(16'h002e, 16'h0000, 1);
    wr(16'h002c, 16'h0001, 1);
    rd(16'h002c, 16'h0001);
    wr(16'h002c, 16'h0000, 1);
  endtask
  task automatic t_range();
    mc("in512", 24'h07fffe, 1'b1, 1'b0, 1'b1);
    mc("out_rd", 24'h080000, 1'b1, 1'b0, 1'b0);
    mc("out_wr", 24'h080000, 1'b1, 1'b1, 1'b0);
    mc("io", 24'h000100, 1'b0, 1'b0, 1'b0);
    wr(16'h002a, 16'h841f, 1);
    mc("r1_in", 24'h27fffe, 1'b1, 1'b0, 1'b1);
    mc("r1_out", 24'h280000, 1'b1, 1'b0, 1'b0);
    wr(16'h0028, 16'h001f, 1);
    mc("r0_off", 24'h000000, 1'b1, 1'b0, 1'b0);
    wr(16'h002a, 16'h0000, 1);
    mc("none_rd", 24'h200000, 1'b1, 1'b0, 1'b0);
    mc("none_wr", 24'h000100, 1'b1, 1'b1, 1'b0);
    wr(16'h002a, 16'h8400, 1);
    mc("nomask", 24'h600000, 1'b1, 1'b0, 1'b1);
    wr(16'h002a, 16'h0000, 1);
    wr(16'h0028, 16'h801e, 1);
    mc("base512", 24'h080000, 1'b1, 1'b0, 1'b0);
    bsz = 1'b1;
    mc("base640", 24'h080000, 1'b1, 1'b0, 1'b1);
    mc("vid_off", 24'h0a0000, 1'b1, 1'b0, 1'b0);
    vid = 1'b1;
    mc("vid_on", 24'h0a0000, 1'b1, 1'b0, 1'b1);
  endtask
  task automatic t_rom();
    logic [23:0] a;
    logic        sup;
    for (int k = 0; k < 16; k++) begin
      rsz = k[3];
      bios = k[2];
      a = {k[1] ? 4'hf : 4'h0, 3'b111, k[0], 16'h0000};
      sup = k[2] && !k[1];
      u_host.mem_cyc(a, 1'b1, 1'b0, wb);
      chk("rom", 24'({rom_lo_n, rom_hi_n}),
          24'({sup || k[3] || k[0], !(!sup && (k[3] || k[0]))}));
    end
    rsz = 1'b0;
    bios = 1'b0;
  endtask
  task automatic t_speed();
    wr(16'h002c, 16'h8000, 6);
    chk("fast", 24'({spd, t_states}), 24'h000018);
    pulses(8);
    wr(16'h002c, 16'h8000, 1);
    wr(16'h002c, 16'h0000, 6);
    chk("slow", 24'({spd, t_states}), 24'h000006);
    pulses(10);
  endtask
  task automatic t_shadow();
    bios = 1'b1;
    wr(16'h002e, 16'hf110, 1);
    wr(16'h002c, 16'h0001, 1);
    u_host.mem_cyc(24'h0e0000, 1'b1, 1'b1, wb);
    chk("wp_set", 24'(wb), 24'h000001);
    mc("wp_clr", 24'h0e8000, 1'b1, 1'b1, 1'b1);
    chk("wp_clr_blk", 24'(wb), 24'h000000);
    mc("c0_noadp", 24'h0c0000, 1'b1, 1'b0, 1'b0);
    adp = 1'b1;
    mc("c0_adp", 24'h0c0000, 1'b1, 1'b0, 1'b1);
    mc("c8_off", 24'h0c8000, 1'b1, 1'b0, 1'b0);
    wr(16'h002c, 16'h0000, 1);
    u_host.mem_cyc(24'h0e0000, 1'b1, 1'b1, wb);
    chk("coarse_wp", 24'(wb), 24'h000000);
  endtask
  task automatic t_lock();
    lock = 1'b1;
    for (int k = 0; k < 4; k++) begin
      u_host.io_acc(k[0], 16'h0028 + 16'(2 * k), 16'h0000, q, n, h);
      chk("locked", 24'({h, n == -1}), 24'h000001);
    end
    lock = 1'b0;
    u_host.io_acc(1'b1, 16'h0028, 16'h0000, q, n, h);
    chk("still_locked", 24'({h, n == -1}), 24'h000001);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    rd(16'h0028, 16'h801f);
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk_i);
    sys_rst_i = 1'b0;
    t_regs();
    t_range();
    t_rom();
    t_speed();
    t_shadow();
    t_lock();
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== bench/host_bus_model.sv
/*
  Host bus model: register and memory cycles toward the block.
  Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/1ns
`default_nettype none
module host_bus_model (
  input  wire logic        clk_i,    // Bus clock.
  input  wire logic        ready_i,  // Register ready.
  input  wire logic [15:0] rdata_i,  // Read data.
  input  wire logic        hit_i,    // Register hit.
  input  wire logic        blk_i,    // Write blocked.
  output logic      [15:0] addr_o,   // Register address.
  output logic      [15:0] wdata_o,  // Write data.
  output logic             wr_o,     // Write strobe.
  output logic             rd_o,     // Read strobe.
  output logic      [23:0] maddr_o,  // Cycle address.
  output logic             mio_o,    // High for memory.
  output logic             mwr_o,    // High for write.
  output logic             start_o   // Cycle strobe.
);
  initial begin
    addr_o = 16'h00f0;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    maddr_o = 24'h000000;
    mio_o = 1'b1;
    mwr_o = 1'b0;
    start_o = 1'b0;
  end
  // ==========================================================
  // Register requests hold until ready, memory cycles one clock; released address and data lines show the inverse value.
  task automatic io_acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output int n, output logic h);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = w;
    rd_o = !w;
    #1 h = hit_i;
    n = -1;
    q = 16'h0000;
    for (int i = 1; i <= 30 && n < 0; i++) begin
      @(negedge clk_i);
      if (ready_i === 1'b1) begin
        n = i;
        q = rdata_i;
      end
    end
    if (n > 0)
      @(negedge clk_i);
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic mem_cyc(input logic [23:0] a, input logic m, input logic w,
                         output logic b);
    @(negedge clk_i);
    maddr_o = a;
    mio_o = m;
    mwr_o = w;
    start_o = 1'b1;
    #1 b = blk_i;
    @(negedge clk_i);
    start_o = 1'b0;
    maddr_o = ~a;
  endtask
endmodule
`default_nettype wire

// ===== logic/addr_decode_shadow.sv
/*
  Address decode and shadow map: local range compare, granularity and
  speed control, 32K shadow blocks, ROM selects, first megabyte select
  and on-board memory indication.
  Assumes the memory configuration register lives elsewhere and drives
  the lock and configuration bits; I/O strobes are held through the ready cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module addr_decode_shadow (
  input  wire logic        core_clk_i,           // 20 MHz clock.
  input  wire logic        sys_rst_i,            // Synchronous reset.
  input  wire logic [15:0] io_addr_i,            // I/O register address.
  input  wire logic [15:0] io_wdata_i,           // I/O write data.
  input  wire logic        io_wr_i,              // I/O write strobe.
  input  wire logic        io_rd_i,              // I/O read strobe.
  output logic      [15:0] io_rdata_o,           // I/O read data.
  output logic             io_hit_o,             // Address is a register here.
  output logic             processor_ready_out_o,// Register cycle ready.
  input  wire logic [23:0] mem_addr_i,           // Cycle address.
  input  wire logic        mem_io_i,             // High for memory cycle.
  input  wire logic        mem_wr_i,             // High for write cycle.
  input  wire logic        cycle_start_i,        // Cycle valid strobe.
  input  wire logic        lock_i,               // Configuration lock.
  input  wire logic        bios_shadow_bit_i,    // BIOS shadow enabled.
  input  wire logic        adapter_shadow_bit_i, // Adapter shadow enabled.
  input  wire logic        video_shadow_bit_i,   // Video area shadowed.
  input  wire logic        rom_size_bit_i,       // High for 512K ROM.
  input  wire logic        base_memory_size_bit_i,// High for 640K base.
  output logic             rom_select_low_n_o,   // Low ROM select.
  output logic             rom_select_high_n_o,  // High ROM select.
  output logic             first_megabyte_select_o,// Lower megabyte.
  output logic             onboard_memory_hit_o, // Local DRAM access.
  output logic             offboard_status_0_n_o,// Off-board status 0.
  output logic             offboard_status_1_n_o,// Off-board status 1.
  output logic             offboard_memory_or_io_o,// Off-board M/IO.
  output logic             write_blocked_o,      // Write to protected block.
  output logic             speed_select_o,       // Current speed select.
  output logic [3:0]       t_states_o,           // Non-turbo T-states.
  output logic             pclk_o,               // Peripheral clock.
  output logic             pclk_en_o             // Peripheral clock enable.
);
  typedef enum logic [2:0] {
    IDLE   = 3'b001,
    SWITCH = 3'b010,
    READY  = 3'b100
  } rdy_state_t;

  logic [15:0] local_range_compare_0;
  logic [15:0] local_range_compare_1;
  logic [15:0] granularity_speed_control;
  logic [15:0] shadow_block_protect;
  rdy_state_t  rdy_state;
  logic [4:0]  wait_cnt;
  logic        unlocked;
  logic        fine_shadow_select;
  logic        speed_select;
  logic [7:0]  block_shadow_enable_bits;
  logic [7:0]  block_write_protect_bits;
  logic        sel_r0;
  logic        sel_r1;
  logic        sel_gs;
  logic        sel_sh;
  logic        speed_change;
  logic        range_hit;
  logic        in_low_meg;
  logic        in_bios_lo;
  logic        in_bios_hi;
  logic        in_adapter;
  logic        in_video;
  logic        in_base_gap;
  logic [1:0]  blk;
  logic        area_shadowed;
  logic        area_protected;
  logic        local_hit;
  logic        rom_lo_dec;
  logic        rom_hi_dec;
  logic        lock_seen;

  // Lock is sticky: once seen it holds until system reset.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      lock_seen <= 1'b0;
    end else if (lock_i) begin
      lock_seen <= 1'b1;
    end
  end
  assign unlocked = !lock_i && !lock_seen;
  assign fine_shadow_select       = granularity_speed_control[addr_map_pkg::FINE_SHADOW_BIT];
  assign speed_select             = granularity_speed_control[addr_map_pkg::SPEED_BIT];
  assign block_shadow_enable_bits = shadow_block_protect[addr_map_pkg::SHADOW_EN_LSB +: 8];
  assign block_write_protect_bits = shadow_block_protect[addr_map_pkg::PROTECT_LSB +: 8];

  // ==========================================================
  // Register decode
  assign sel_r0 = unlocked && io_addr_i == addr_map_pkg::ADDR_RANGE0;
  assign sel_r1 = unlocked && io_addr_i == addr_map_pkg::ADDR_RANGE1;
  assign sel_gs = unlocked && io_addr_i == addr_map_pkg::ADDR_GRAN_SPEED;
  assign sel_sh = unlocked && io_addr_i == addr_map_pkg::ADDR_SHADOW;
  assign io_hit_o = sel_r0 || sel_r1 || sel_gs || sel_sh;
  assign speed_change = io_wr_i && sel_gs && rdy_state == IDLE &&
                        io_wdata_i[addr_map_pkg::SPEED_BIT] != speed_select;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      local_range_compare_0 <= addr_map_pkg::RANGE0_RESET;
      local_range_compare_1 <= addr_map_pkg::RANGE1_RESET;
    end else if (io_wr_i && rdy_state == IDLE) begin
      if (sel_r0) begin
        local_range_compare_0 <= io_wdata_i;
      end
      if (sel_r1) begin
        local_range_compare_1 <= io_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      granularity_speed_control <= addr_map_pkg::GRAN_RESET;
      shadow_block_protect      <= addr_map_pkg::SHADOW_RESET;
    end else if (io_wr_i && rdy_state == IDLE) begin
      if (sel_gs) begin
        granularity_speed_control <= io_wdata_i & addr_map_pkg::GRAN_WRITABLE;
      end
      if (sel_sh) begin
        shadow_block_protect <= io_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      io_rdata_o <= 16'h0000;
    end else if (io_rd_i) begin
      io_rdata_o <= sel_r0 ? local_range_compare_0 :
                    sel_r1 ? local_range_compare_1 :
                    sel_gs ? granularity_speed_control :
                    sel_sh ? shadow_block_protect : 16'h0000;
    end
  end

  // ==========================================================
  // Ready: speed changes hold ready until the divider has switched.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdy_state <= IDLE;
      wait_cnt  <= 5'h00;
    end else begin
      case (rdy_state)
        IDLE: begin
          wait_cnt <= 5'h00;
          if (speed_change) begin
            rdy_state <= SWITCH;
          end else if ((io_wr_i || io_rd_i) && io_hit_o) begin
            rdy_state <= READY;
          end
        end
        SWITCH: begin
          wait_cnt <= wait_cnt + 5'h01;
          if (wait_cnt == addr_map_pkg::SWITCH_WAIT) begin
            rdy_state <= READY;
          end
        end
        READY: rdy_state <= IDLE;
        default: rdy_state <= IDLE;
      endcase
    end
  end
  assign processor_ready_out_o = rdy_state == READY;

  pclk_divider u_div (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .div_25_i   (speed_select),
    .pclk_en_o  (pclk_en_o),
    .pclk_o     (pclk_o)
  );
  assign speed_select_o = speed_select;
  assign t_states_o = speed_select ? 4'(addr_map_pkg::T_STATES_FAST_DIV) :
                                     4'(addr_map_pkg::T_STATES_SLOW_DIV);

  // ==========================================================
  // Local range compare
  function automatic logic range_match(input logic [15:0] r, input logic [23:0] a);
    logic [4:0] d;
    logic [4:0] m;
    d = r[addr_map_pkg::RC_DATA_LSB +: 5];
    m = r[addr_map_pkg::RC_MASK_LSB +: 5];
    range_match = r[addr_map_pkg::RC_EN_BIT] && (((a[23:19] ^ d) & m) == 5'h00);
  endfunction

  assign range_hit = range_match(local_range_compare_0, mem_addr_i) ||
                     range_match(local_range_compare_1, mem_addr_i);

  // ==========================================================
  // Area classification below one megabyte and in the top 128K ROM area
  assign in_low_meg  = mem_addr_i[23:20] == 4'h0;
  assign in_base_gap = in_low_meg && mem_addr_i[19:17] == 3'h4;
  assign in_video    = in_low_meg && mem_addr_i[19:17] == 3'h5;
  assign in_adapter  = in_low_meg && mem_addr_i[19:17] == 3'h6;
  assign in_bios_lo  = in_low_meg && mem_addr_i[19:17] == 3'h7;
  assign in_bios_hi  = mem_addr_i[23:17] == 7'h7f;
  assign blk = mem_addr_i[16:15];

  always_comb begin
    area_shadowed  = 1'b0;
    area_protected = 1'b0;
    if (in_adapter || in_bios_lo) begin
      if (fine_shadow_select) begin
        area_shadowed = (in_adapter ? adapter_shadow_bit_i : bios_shadow_bit_i) &&
                        block_shadow_enable_bits[{in_bios_lo, blk}];
        area_protected = block_write_protect_bits[{in_bios_lo, blk}];
      end else begin
        area_shadowed = in_adapter ? adapter_shadow_bit_i : bios_shadow_bit_i;
      end
    end
  end

  always_comb begin
    local_hit = mem_io_i && range_hit;
    if ((in_base_gap && !base_memory_size_bit_i) ||
        (in_video && !video_shadow_bit_i) ||
        ((in_adapter || in_bios_lo) && !area_shadowed)) begin
      local_hit = 1'b0;
    end
  end

  assign write_blocked_o = cycle_start_i && local_hit && mem_wr_i && area_protected;

  // ==========================================================
  // ROM selects
  assign rom_lo_dec = mem_io_i && ((in_bios_lo && !bios_shadow_bit_i) || in_bios_hi);
  assign rom_hi_dec = mem_io_i && ((in_bios_lo && !bios_shadow_bit_i) || in_bios_hi);

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rom_select_low_n_o  <= 1'b1;
      rom_select_high_n_o <= 1'b1;
    end else if (rom_size_bit_i) begin
      rom_select_low_n_o  <= 1'b1;
      rom_select_high_n_o <= !rom_hi_dec;
    end else begin
      rom_select_low_n_o  <= !(rom_lo_dec && !mem_addr_i[16]);
      rom_select_high_n_o <= !(rom_lo_dec && mem_addr_i[16]);
    end
  end

  // ==========================================================
  // Cycle outputs
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      first_megabyte_select_o <= 1'b0;
      onboard_memory_hit_o    <= 1'b0;
      offboard_status_0_n_o   <= 1'b1;
      offboard_status_1_n_o   <= 1'b1;
      offboard_memory_or_io_o <= 1'b0;
    end else begin
      first_megabyte_select_o <= mem_io_i && in_low_meg;
      onboard_memory_hit_o    <= local_hit;
      offboard_status_0_n_o   <= !(cycle_start_i && !local_hit && mem_wr_i);
      offboard_status_1_n_o   <= !(cycle_start_i && !local_hit && !mem_wr_i);
      offboard_memory_or_io_o <= mem_io_i;
    end
  end

  // ==========================================================
  // Checks
  AST_RESET_RANGE: assert property (@(posedge core_clk_i)
    $fell(sys_rst_i) |-> local_range_compare_0 == addr_map_pkg::RANGE0_RESET &&
    !local_range_compare_1[addr_map_pkg::RC_EN_BIT])
    else $error("range reset values wrong");
  AST_LOCKED: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !unlocked && io_wr_i |=> $stable(local_range_compare_0) &&
    $stable(granularity_speed_control) && $stable(shadow_block_protect))
    else $error("write landed while locked");
  AST_NO_RANGE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !local_range_compare_0[15] && !local_range_compare_1[15] |=> !onboard_memory_hit_o)
    else $error("local hit with both ranges off");
  AST_SPEED_READY: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    speed_change |-> ##[1:21] processor_ready_out_o)
    else $error("speed switch ready too late");
  AST_ROM512: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    rom_size_bit_i |=> rom_select_low_n_o)
    else $error("low ROM select active at 512K");
  AST_IO_MEG: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !mem_io_i |=> !first_megabyte_select_o)
    else $error("megabyte select on I/O");
  AST_TSTATES: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !speed_select |-> t_states_o == 4'h6)
    else $error("slow T-states wrong");
  AST_GRAN_MASK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (granularity_speed_control & 16'h7ffe) == 16'h0000)
    else $error("reserved granularity bits set");
  AST_LOCK_READ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !unlocked && io_rd_i |=> io_rdata_o == 16'h0000)
    else $error("locked register read returned data");
  AST_READY_PULSE: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    processor_ready_out_o |=> !processor_ready_out_o)
    else $error("ready held longer than one cycle");
  AST_BIOS_SUPPRESS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mem_io_i && in_bios_lo && bios_shadow_bit_i |=> rom_select_low_n_o && rom_select_high_n_o)
    else $error("ROM select active in shadowed BIOS range");
  AST_TOP_ROM256: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mem_io_i && in_bios_hi && !rom_size_bit_i |=> rom_select_low_n_o != rom_select_high_n_o)
    else $error("top ROM range not decoded by exactly one select");
  AST_LOCAL_STATUS: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cycle_start_i && local_hit |=> onboard_memory_hit_o && offboard_status_0_n_o &&
    offboard_status_1_n_o)
    else $error("local cycle drove off-board status");
  AST_COARSE_WP: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !fine_shadow_select |-> !write_blocked_o)
    else $error("block protect applied in coarse mode");
  AST_IO_LOCAL: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !mem_io_i |=> !onboard_memory_hit_o)
    else $error("on-board hit on I/O cycle");
  COV_SPEED: cover property (@(posedge core_clk_i) speed_change ##[1:21] processor_ready_out_o);
  COV_LOCAL: cover property (@(posedge core_clk_i) onboard_memory_hit_o);
  COV_PROT: cover property (@(posedge core_clk_i) write_blocked_o);
  COV_LOCKED: cover property (@(posedge core_clk_i) !unlocked && io_wr_i);
  COV_ROM512: cover property (@(posedge core_clk_i) rom_size_bit_i && !rom_select_high_n_o);
endmodule
`default_nettype wire

// ===== logic/addr_map_pkg.sv
/*
  Constants for the address decode and shadow map block: register
  addresses, field positions, reset values and clock divider timing.
  Assumes a single core clock and word-wide I/O register accesses.
*/
package addr_map_pkg;
  // ==========================================================
  // Register I/O addresses
  localparam logic [15:0] ADDR_RANGE0     = 16'h0028;
  localparam logic [15:0] ADDR_RANGE1     = 16'h002a;
  localparam logic [15:0] ADDR_GRAN_SPEED = 16'h002c;
  localparam logic [15:0] ADDR_SHADOW     = 16'h002e;
  // ==========================================================
  // Range compare register fields: enable, compare data, mask
  localparam int RC_EN_BIT   = 15;
  localparam int RC_DATA_LSB = 8;
  localparam int RC_MASK_LSB = 0;
  localparam int RC_FIELD_W  = 5;
  // ==========================================================
  // Reset values: range 0 enabled at 512K, range 1 disabled
  localparam logic [15:0] RANGE0_RESET = 16'h801f;
  localparam logic [15:0] RANGE1_RESET = 16'h0000;
  localparam logic [15:0] GRAN_RESET   = 16'h0000;
  localparam logic [15:0] SHADOW_RESET = 16'h0000;
  // ==========================================================
  // Granularity and speed control fields
  localparam int FINE_SHADOW_BIT = 0;
  localparam int SPEED_BIT       = 15;
  localparam logic [15:0] GRAN_WRITABLE = 16'h8001;
  // ==========================================================
  // Shadow block register fields
  localparam int SHADOW_EN_LSB = 8;
  localparam int PROTECT_LSB   = 0;
  localparam int BLOCKS        = 8;
  // ==========================================================
  // Peripheral clock and cycle timing
  localparam int T_STATES_SLOW_DIV = 6;
  localparam int T_STATES_FAST_DIV = 8;
  localparam int SWITCH_WAIT_MAX   = 20;
  localparam logic [4:0] SWITCH_WAIT = 5'h04;
endpackage

// ===== logic/pclk_divider.sv
/*
  Peripheral clock enable generator: divides the oscillator clock by 2
  or by 2.5 (five cycles per two pulses modelled as 2,3 pattern).
  Assumes the oscillator rate is the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module pclk_divider (
  input  wire logic core_clk_i,   // Oscillator clock.
  input  wire logic sys_rst_i,    // Synchronous reset.
  input  wire logic div_25_i,     // High selects divide by 2.5.
  output logic      pclk_en_o,    // Peripheral clock enable pulse.
  output logic      pclk_o        // Peripheral clock level.
);
  logic [2:0] phase;
  logic [2:0] limit;
  logic       mode;

  assign limit = mode ? 3'h4 : 3'h1;

  // ==========================================================
  // Phase counter, mode only changes at a period boundary.
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      phase <= 3'h0;
      mode  <= 1'b0;
    end else if (phase >= limit) begin
      phase <= 3'h0;
      mode  <= div_25_i;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pclk_o    <= 1'b0;
      pclk_en_o <= 1'b0;
    end else begin
      pclk_en_o <= (phase >= limit) || (mode && phase == 3'h1);
      pclk_o    <= mode ? (phase < 3'h2) : (phase == 3'h0);
    end
  end
endmodule
`default_nettype wire
